// ### hw/pdtoc_top.sv
// Contract
// R1: Second divider: codes 0,1,2 divide 1,2,4
// R2: First divider: codes 0,1,2 divide 5,4,3
// R3: Software resets synthesizer before first/second change
// R4: Third divider divides by value, reset 32
// R5: Software resets synthesizer before third change
// R6: Software rewrites reserved fields with reset values
// R7: Software programs bias 0x4A, not 0x4F
// R8: One pre-emphasis code drives all lanes
// R9: Trigger enable gates trigger buffer and divider
// R10: Mode picks 16/32/64 UI clock or timestamp
// R11: Software changes mode only while disabled
// R12: Serializer re-initialization interrupts UI-clock trigger
`include "pdtoc_consts.svh"
`default_nettype none
module pdtoc_top
(
	input wire logic clk_sys_in,
	input wire logic nrst_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic clock_synth_reset_in,
	input wire logic ui_tick_in,
	input wire logic serializer_reinit_in,
	input wire logic timestamp_input_in,
	output logic [7:0] reg_rdata_out,
	output logic sample_tick_out,
	output logic pfd_fb_tick_out,
	output logic [6:0] oscillator_bias_level_out,
	output logic [3:0] lane_preemphasis_code_out,
	output logic trigger_out_enable_out,
	output logic trigger_out_pin_out
);
	// ==========================================
	// Decode functions
	function automatic pdtoc_pkg::pdtoc_ratio_t v_ratio(input logic [1:0] c);
		v_ratio = (c == 2'h0) ? `PDTOC_V_CODE0 :
			(c == 2'h1) ? `PDTOC_V_CODE1 :
			(c == 2'h2) ? `PDTOC_V_CODE2 : `PDTOC_RATIO_OFF;
	endfunction

	function automatic pdtoc_pkg::pdtoc_ratio_t p_ratio(input logic [1:0] c);
		p_ratio = (c == 2'h0) ? `PDTOC_P_CODE0 :
			(c == 2'h1) ? `PDTOC_P_CODE1 :
			(c == 2'h2) ? `PDTOC_P_CODE2 : `PDTOC_RATIO_OFF;
	endfunction

	function automatic pdtoc_pkg::pdtoc_ratio_t trig_half(input logic [2:0] m);
		trig_half = (m == 3'h0) ? `PDTOC_HALF_UI16 :
			(m == 3'h1) ? `PDTOC_HALF_UI32 :
			(m == 3'h2) ? `PDTOC_HALF_UI64 : `PDTOC_RATIO_OFF;
	endfunction

	// ==========================================
	// Register file
	// Reserved bits are stored as written and read back unchanged
	pdtoc_pkg::pdtoc_byte_t fb_pv_r;
	pdtoc_pkg::pdtoc_byte_t fb_n_r;
	pdtoc_pkg::pdtoc_byte_t bias_r;
	pdtoc_pkg::pdtoc_byte_t pe_r;
	pdtoc_pkg::pdtoc_byte_t trig_r;
	pdtoc_pkg::pdtoc_byte_t rdata_nxt;

	wire logic hit_pv = reg_addr_in == `PDTOC_OFS_FB_PV;
	wire logic hit_n = reg_addr_in == `PDTOC_OFS_FB_N;
	wire logic hit_bias = reg_addr_in == `PDTOC_OFS_BIAS;
	wire logic hit_pe = reg_addr_in == `PDTOC_OFS_PE;
	wire logic hit_trig = reg_addr_in == `PDTOC_OFS_TRIG;

	assign rdata_nxt = hit_pv ? fb_pv_r :
		hit_n ? fb_n_r :
		hit_bias ? bias_r :
		hit_pe ? pe_r :
		hit_trig ? trig_r : 8'h00;

	always_ff @(posedge clk_sys_in)
	begin
		if (!nrst_in)
		begin
			fb_pv_r <= `PDTOC_RST_FB_PV;
			fb_n_r <= `PDTOC_RST_FB_N; // R4
			bias_r <= `PDTOC_RST_BIAS;
			pe_r <= `PDTOC_RST_PE;
			trig_r <= `PDTOC_RST_TRIG;
		end
		else if (reg_wr_in)
		begin
			if (hit_pv)
				fb_pv_r <= reg_wdata_in;
			if (hit_n)
				fb_n_r <= reg_wdata_in;
			if (hit_bias)
				bias_r <= reg_wdata_in;
			if (hit_pe)
				pe_r <= reg_wdata_in;
			if (hit_trig)
				trig_r <= reg_wdata_in;
		end
	end

	always_ff @(posedge clk_sys_in)
	begin
		if (!nrst_in)
			reg_rdata_out <= 8'h00;
		else if (reg_rd_in)
			reg_rdata_out <= rdata_nxt;
	end

	// ==========================================
	// Feedback divider chain
	// Core clock stands in for the oscillator; each stage counts ticks
	pdtoc_div_if #(.W(6)) v_if ();
	pdtoc_div_if #(.W(6)) p_if ();
	pdtoc_div_if #(.W(6)) n_if ();

	assign v_if.tick_in = 1'b1;
	assign v_if.ratio = v_ratio(fb_pv_r[`PDTOC_V_MSB:`PDTOC_V_LSB]); // R2
	assign p_if.tick_in = v_if.tick_out;
	assign p_if.ratio = p_ratio(fb_pv_r[`PDTOC_P_MSB:`PDTOC_P_LSB]); // R1
	assign n_if.tick_in = p_if.tick_out;
	assign n_if.ratio = fb_n_r[`PDTOC_N_MSB:0]; // R4

	// Held in reset by software while ratios change, so no runt tick
	pdtoc_divider #(.W(6)) u_vdiv
	(
		.clk_sys_in(clk_sys_in),
		.nrst_in(nrst_in),
		.clear_in(clock_synth_reset_in),
		.dif(v_if.div)
	);

	pdtoc_divider #(.W(6)) u_pdiv
	(
		.clk_sys_in(clk_sys_in),
		.nrst_in(nrst_in),
		.clear_in(clock_synth_reset_in),
		.dif(p_if.div)
	);

	pdtoc_divider #(.W(6)) u_ndiv
	(
		.clk_sys_in(clk_sys_in),
		.nrst_in(nrst_in),
		.clear_in(clock_synth_reset_in),
		.dif(n_if.div)
	);

	// ==========================================
	// Trigger output
	pdtoc_pkg::pdtoc_trig_mode_t trig_mode;
	logic trig_clk_r;
	logic tstamp_r;
	logic trig_nxt;
	pdtoc_div_if #(.W(6)) t_if ();

	assign trig_mode = pdtoc_pkg::pdtoc_trig_mode_t'(
		trig_r[`PDTOC_TRIG_MODE_MSB:0]);
	wire logic trig_en = trig_r[`PDTOC_TRIG_EN_BIT];
	wire logic ui_mode = trig_r[`PDTOC_TRIG_MODE_MSB:0] <= 3'h2;
	wire logic ts_mode = trig_mode == pdtoc_pkg::PDTOC_TRIG_TSTAMP;
	wire logic trig_hold = !trig_en || !ui_mode || serializer_reinit_in;

	assign t_if.tick_in = ui_tick_in;
	assign t_if.ratio = trig_half(trig_r[`PDTOC_TRIG_MODE_MSB:0]); // R10

	pdtoc_divider #(.W(6)) u_tdiv
	(
		.clk_sys_in(clk_sys_in),
		.nrst_in(nrst_in),
		.clear_in(trig_hold), // R9
		.dif(t_if.div)
	);

	// Reserved modes leave the pin low
	assign trig_nxt = !trig_en ? 1'b0 : // R9
		(ui_mode && !serializer_reinit_in) ? trig_clk_r : // R12
		ts_mode ? tstamp_r : 1'b0; // R10

	always_ff @(posedge clk_sys_in)
	begin
		if (!nrst_in || trig_hold)
			trig_clk_r <= 1'b0;
		else if (t_if.tick_out)
			trig_clk_r <= !trig_clk_r;
	end

	// ==========================================
	// Output registers
	always_ff @(posedge clk_sys_in)
	begin
		if (!nrst_in)
		begin
			tstamp_r <= 1'b0;
			sample_tick_out <= 1'b0;
			pfd_fb_tick_out <= 1'b0;
			oscillator_bias_level_out <= 7'h00;
			lane_preemphasis_code_out <= 4'h0;
			trigger_out_enable_out <= 1'b0;
			trigger_out_pin_out <= 1'b0;
		end
		else
		begin
			tstamp_r <= timestamp_input_in;
			sample_tick_out <= p_if.tick_out;
			pfd_fb_tick_out <= n_if.tick_out;
			oscillator_bias_level_out <= bias_r[`PDTOC_BIAS_MSB:0];
			lane_preemphasis_code_out <= pe_r[`PDTOC_PE_MSB:0]; // R8
			trigger_out_enable_out <= trig_en;
			trigger_out_pin_out <= trig_nxt;
		end
	end

	// ==========================================
	// Assertions
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!nrst_in);

	v_ratio_a: assert property (disable iff (!nrst_in || // R2
		clock_synth_reset_in) (fb_pv_r[1:0] == 2'h0) [*6] ##0
		v_if.tick_out |=> !v_if.tick_out [*4] ##1 v_if.tick_out)
		else $error("first divider code 0 not divide by 5");
	p_ratio_a: assert property ((fb_pv_r[3:2] == 2'h2) |-> // R1
		(p_if.ratio == 6'h04))
		else $error("second divider code 2 not divide by 4");
	n_ratio_a: assert property (n_if.ratio == fb_n_r[5:0]) // R4
		else $error("third divider ratio differs from register");
	n_reset_a: assert property (disable iff (1'b0) // R4
		!nrst_in |=> (fb_n_r == 8'h20))
		else $error("third divider reset value not 32");
	pe_copy_a: assert property ($changed(pe_r) |=> // R8
		(lane_preemphasis_code_out == $past(pe_r[3:0])))
		else $error("pre-emphasis code not applied");
	trig_off_a: assert property (!trig_en |=> !trigger_out_pin_out) // R9
		else $error("trigger pin active while disabled");
	trig_ts_a: assert property ((trig_en && ts_mode) [*2] |=> // R10
		(trigger_out_pin_out == $past(timestamp_input_in, 2)))
		else $error("timestamp not resampled onto trigger");
	trig_rsv_a: assert property ((trig_r[2:0] >= 3'h4) |=> // R10
		!trigger_out_pin_out)
		else $error("reserved trigger mode drives pin");
	reinit_a: assert property ((ui_mode && serializer_reinit_in) |=> // R12
		!trigger_out_pin_out)
		else $error("trigger not interrupted by reinit");
	sample_gap_a: assert property (disable iff (!nrst_in || // R2
		clock_synth_reset_in) (fb_pv_r[3:0] == 4'h0) [*6] ##0
		sample_tick_out |=> !sample_tick_out [*4] ##1 sample_tick_out)
		else $error("sample ticks not five cycles apart");

	fb_tick_c: cover property (pfd_fb_tick_out);
	trig_clk_c: cover property (trig_en && ui_mode && trigger_out_pin_out);
	trig_ts_c: cover property (trig_en && ts_mode && trigger_out_pin_out);
	reinit_c: cover property (trig_en && ui_mode && serializer_reinit_in);
endmodule // pdtoc_top
`default_nettype wire

// ### inc/pdtoc_consts.svh
`ifndef PDTOC_CONSTS_SVH
`define PDTOC_CONSTS_SVH
// ==========================================
// Register offsets
`define PDTOC_OFS_FB_PV 8'h3d
`define PDTOC_OFS_FB_N 8'h3e
`define PDTOC_OFS_BIAS 8'h3f
`define PDTOC_OFS_PE 8'h48
`define PDTOC_OFS_TRIG 8'h57
// ==========================================
// Reset values
`define PDTOC_RST_FB_PV 8'h00
`define PDTOC_RST_FB_N 8'h20
`define PDTOC_RST_BIAS 8'h4f
`define PDTOC_RST_PE 8'h00
`define PDTOC_RST_TRIG 8'h00
// ==========================================
// Field positions
`define PDTOC_V_LSB 0
`define PDTOC_V_MSB 1
`define PDTOC_P_LSB 2
`define PDTOC_P_MSB 3
`define PDTOC_N_MSB 5
`define PDTOC_BIAS_MSB 6
`define PDTOC_PE_MSB 3
`define PDTOC_TRIG_EN_BIT 7
`define PDTOC_TRIG_MODE_MSB 2
// ==========================================
// Divide ratios
`define PDTOC_V_CODE0 6'h05
`define PDTOC_V_CODE1 6'h04
`define PDTOC_V_CODE2 6'h03
`define PDTOC_P_CODE0 6'h01
`define PDTOC_P_CODE1 6'h02
`define PDTOC_P_CODE2 6'h04
`define PDTOC_HALF_UI16 6'h08
`define PDTOC_HALF_UI32 6'h10
`define PDTOC_HALF_UI64 6'h20
`define PDTOC_RATIO_OFF 6'h00
`endif

// ### inc/pdtoc_pkg.sv
`default_nettype none
package pdtoc_pkg;
	typedef logic [7:0] pdtoc_byte_t;
	typedef logic [5:0] pdtoc_ratio_t;
	typedef enum logic [2:0]
	{
		PDTOC_TRIG_UI16,
		PDTOC_TRIG_UI32,
		PDTOC_TRIG_UI64,
		PDTOC_TRIG_TSTAMP
	} pdtoc_trig_mode_t;
endpackage
`default_nettype wire

// ### inc/pdtoc_div_if.sv
`default_nettype none
interface pdtoc_div_if #(parameter int W = 6);
	logic tick_in;
	logic [W-1:0] ratio;
	logic tick_out;
	modport ctrl (output tick_in, output ratio, input tick_out);
	modport div (input tick_in, input ratio, output tick_out);
endinterface
`default_nettype wire

// ### hw/pdtoc_divider.sv
`default_nettype none
module pdtoc_divider #(parameter int W = 6)
(
	input wire logic clk_sys_in,
	input wire logic nrst_in,
	input wire logic clear_in,
	pdtoc_div_if.div dif
);
	// ==========================================
	// Counter
	// Ratio zero stands the divider still, used for reserved codes
	logic [W-1:0] cnt_r;
	logic tick_r;
	wire logic live = dif.ratio != '0;
	wire logic wrap = dif.tick_in && live && (cnt_r == dif.ratio - 1'b1);

	always_ff @(posedge clk_sys_in)
	begin
		if (!nrst_in || clear_in || !live)
		begin
			cnt_r <= '0;
			tick_r <= 1'b0;
		end
		else
		begin
			tick_r <= wrap;
			if (wrap)
				cnt_r <= '0;
			else if (dif.tick_in)
				cnt_r <= cnt_r + 1'b1;
		end
	end

	assign dif.tick_out = tick_r;
endmodule // pdtoc_divider
`default_nettype wire

// ### verification/pdtoc_top_bench.sv
`default_nettype none
// ==========================================
// Bench for the clock synthesizer configuration block
module pdtoc_top_bench;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_sys_in = 1'b0;
	logic nrst_in = 1'b0;
	logic reg_wr_in = 1'b0;
	logic reg_rd_in = 1'b0;
	logic csr = 1'b1;
	logic ui_tick_in = 1'b1;
	logic ui_slow = 1'b0;
	logic reinit = 1'b0;
	logic ts = 1'b0;
	logic [7:0] reg_addr_in = 8'h00;
	logic [7:0] reg_wdata_in = 8'h00;
	logic [7:0] rdata;
	logic sample_tick, pfd_tick, en_out, pin;
	logic [6:0] bias;
	logic [3:0] pe;
	int failures = 0;
	int compares = 0;
	int cur = 0;
	logic [7:0] ofs [5] = '{8'h3d, 8'h3e, 8'h3f, 8'h48, 8'h57};
	logic [7:0] rstv [5] = '{8'h00, 8'h20, 8'h4f, 8'h00, 8'h00};
	// Reserved bits stay at reset value, enable stays off
	logic [7:0] mask [5] = '{8'h0f, 8'h3f, 8'h7f, 8'h0f, 8'h07};

	pdtoc_top dut
	(
		.clk_sys_in(clk_sys_in),
		.nrst_in(nrst_in),
		.reg_addr_in(reg_addr_in),
		.reg_wdata_in(reg_wdata_in),
		.reg_wr_in(reg_wr_in),
		.reg_rd_in(reg_rd_in),
		.clock_synth_reset_in(csr),
		.ui_tick_in(ui_tick_in),
		.serializer_reinit_in(reinit),
		.timestamp_input_in(ts),
		.reg_rdata_out(rdata),
		.sample_tick_out(sample_tick),
		.pfd_fb_tick_out(pfd_tick),
		.oscillator_bias_level_out(bias),
		.lane_preemphasis_code_out(pe),
		.trigger_out_enable_out(en_out),
		.trigger_out_pin_out(pin)
	);

	always #2 clk_sys_in = ~clk_sys_in;

	// UI ticks on every other cycle when asked, else on every cycle
	always @(posedge clk_sys_in)
	begin
		#1;
		ui_tick_in = ui_slow ? !ui_tick_in : 1'b1;
	end

	// ==========================================
	// Helpers
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			failures++;
			$display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop();
		if (failures == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic cyc();
		@(posedge clk_sys_in);
		#1;
	endtask

	// Idle cycle after each strobe so it is never re-raised in one step
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr_in = a;
		reg_wdata_in = d;
		reg_wr_in = 1'b1;
		cyc();
		reg_wr_in = 1'b0;
		cyc();
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		reg_addr_in = a;
		reg_rd_in = 1'b1;
		cyc();
		reg_rd_in = 1'b0;
		cyc();
		d = rdata;
	endtask

	function automatic int vdiv(input int c);
		return 5 - c;
	endfunction

	// Second gap is measured; the first may follow a restart
	task automatic gap(input int w, input int exp);
		int t0, k;
		logic p, e;
		t0 = 0;
		k = 0;
		p = pin;
		for (int i = 0; i < 4000 && k < 3; i++)
		begin
			cyc();
			e = (w == 0) ? sample_tick : (w == 1) ? pfd_tick : (pin !== p);
			p = pin;
			if (e === 1'b1)
			begin
				if (k == 2)
					chk(i - t0, exp);
				t0 = i;
				k++;
			end
		end
		if (k < 3)
			chk(k, 3);
	endtask

	// Disable before every mode change
	task automatic trig(input int m);
		wr(8'h57, cur[7:0]);
		wr(8'h57, m[7:0]);
		wr(8'h57, 8'h80 | m[7:0]);
		cur = m;
	endtask

	// ==========================================
	// Tests
	initial
	begin
		logic [7:0] d, rb;
		logic hi, h0, h1;
		int i, n;
		void'($urandom(32'hdd93));
		repeat (6) @(posedge clk_sys_in);
		#1;
		nrst_in = 1'b1;
		cyc();
		for (i = 0; i < 5; i++)
		begin
			rd(ofs[i], d);
			chk(d, rstv[i]);
		end
		for (int r = 0; r < 20; r++)
		begin
			i = $urandom_range(4);
			d = 8'($urandom) & mask[i];
			wr(ofs[i], d);
			rd(ofs[i], rb);
			chk(rb, d);
		end
		wr(8'h40, 8'($urandom));
		rd(8'h40, d);
		chk(d, 8'h00);
		d = 8'($urandom) & 8'h0f;
		wr(8'h3f, 8'h4a);
		wr(8'h48, d);
		cyc();
		chk(bias, 7'h4a);
		chk(pe, d[3:0]);
		for (int v = 0; v < 3; v++)
			for (int p = 0; p < 3; p++)
			begin
				n = $urandom_range(3, 1);
				csr = 1'b1;
				wr(8'h3d, 8'((p << 2) | v));
				wr(8'h3e, 8'(n));
				csr = 1'b0;
				gap(0, vdiv(v) * (1 << p));
				gap(1, vdiv(v) * (1 << p) * n);
			end
		csr = 1'b1;
		wr(8'h3d, 8'h02);
		wr(8'h3e, 8'h3f);
		csr = 1'b0;
		gap(1, 189);
		// Reserved first divider code stops the whole chain
		csr = 1'b1;
		wr(8'h3d, 8'h03);
		csr = 1'b0;
		hi = 1'b0;
		repeat (40)
		begin
			cyc();
			hi = hi | sample_tick;
		end
		chk(hi, 1'b0);
		for (int m = 0; m < 3; m++)
		begin
			trig(m);
			chk(en_out, 1'b1);
			gap(2, 8 << m);
		end
		reinit = 1'b1;
		cyc();
		cyc();
		chk(pin, 1'b0);
		repeat (40) cyc();
		chk(pin, 1'b0);
		reinit = 1'b0;
		trig(0);
		ui_slow = 1'b1;
		gap(2, 16);
		ui_slow = 1'b0;
		trig(3);
		h0 = 1'b0;
		h1 = 1'b0;
		for (int k = 0; k < 30; k++)
		begin
			cyc();
			if (k > 2)
				chk(pin, h1);
			h1 = h0;
			h0 = 1'($urandom);
			ts = h0;
		end
		for (int m = 4; m < 8; m++)
		begin
			trig(m);
			hi = 1'b0;
			repeat (40)
			begin
				cyc();
				ts = 1'($urandom);
				hi = hi | pin;
			end
			chk(hi, 1'b0);
		end
		trig(3);
		ts = 1'b1;
		wr(8'h57, 8'h03);
		cyc();
		chk(pin, 1'b0);
		chk(en_out, 1'b0);
		report_and_stop();
	end

	// Whole run needs well under 20000 cycles
	initial
	begin
		#100000;
		failures++;
		report_and_stop();
	end
endmodule // pdtoc_top_bench
`default_nettype wire
